//--- hdl/acsp_port.sv
module acsp_port #(
    parameter int SRST_CYCLES = acsp_pkg::SRST_CYC
) (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    // serial pins
    input  wire logic       sclk_i,
    input  wire logic       port_select_n_i,
    input  wire logic       sdio_i,
    output logic            sdio_o,
    output logic            sdio_oe_o,
    // device side
    output logic            sec_fn_en_o,
    output logic            soft_rst_busy_o,
    output logic [7:0]      term_a_o,
    output logic [7:0]      term_b_o,
    output logic [7:0]      out_mode_o
);
    // ****************************************************************
    // pin synchronisation and edge detection
    // ****************************************************************
    logic [2:0] pin_s;
    logic       sclk_d_r;
    logic       sclk_s;
    logic       sel_n_s;
    logic       sdi_s;
    logic       rise;
    logic       fall;

    acsp_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({sclk_i, port_select_n_i, sdio_i}),
        .q_o      (pin_s)
    );

    // select resets high (idle), so no phantom selection follows reset
    assign sclk_s  = pin_s[2];
    assign sel_n_s = pin_s[1];
    assign sdi_s   = pin_s[0];

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
        end
    end

    assign rise = sclk_s & ~sclk_d_r & ~sel_n_s;
    assign fall = ~sclk_s & sclk_d_r & ~sel_n_s;

    // ****************************************************************
    // frame state
    // ****************************************************************
    acsp_pkg::acsp_state_t state_r;
    logic [3:0]            bcnt_r;
    logic [15:0]           instr_r;
    logic [7:0]            wsh_r;
    logic [7:0]            rsh_r;
    logic [14:0]           addr_r;
    logic                  in_frame_r;
    logic                  lsb_first_r;
    logic                  rdata_load_r;
    acsp_pkg::acsp_req_t   req;
    logic [7:0]            rd_val;
    logic [7:0]            ifcfg_r;
    logic [1:0]            chsel_r;
    logic [7:0]            term_a_r;
    logic [7:0]            term_b_r;
    logic [7:0]            outmode_r;
    logic [31:0]           srst_cnt_r;
    logic                  srst_go;
    logic                  instr_done;
    logic                  byte_done;
    logic [15:0]           instr_nxt;
    logic [7:0]            wsh_nxt;

    // data shift direction follows bit order, instruction always msb first; a word lands the same either way
    assign instr_nxt  = {instr_r[14:0], sdi_s};
    assign wsh_nxt    = lsb_first_r ? {sdi_s, wsh_r[7:1]} : {wsh_r[6:0], sdi_s};
    // sixteen instruction bits, then eight per data word
    assign instr_done = rise && state_r == acsp_pkg::ST_INSTR && bcnt_r == 4'hf;
    assign byte_done  = rise && state_r != acsp_pkg::ST_INSTR && bcnt_r == 4'h7;

    // frame counters; select high holds position, so a stall resumes
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r    <= acsp_pkg::ST_INSTR;
            bcnt_r     <= 4'h0;
            instr_r    <= 16'h0000;
            addr_r     <= 15'h0000;
            in_frame_r <= 1'b0;
        end else if (srst_go) begin
            state_r    <= acsp_pkg::ST_INSTR;
            bcnt_r     <= 4'h0;
            in_frame_r <= 1'b0;
        end else if (rise) begin
            in_frame_r <= 1'b1;
            unique case (state_r)
                acsp_pkg::ST_INSTR: begin
                    instr_r <= instr_nxt;
                    bcnt_r  <= bcnt_r + 4'h1;
                    if (bcnt_r == 4'hf) begin
                        bcnt_r  <= 4'h0;
                        addr_r  <= instr_nxt[14:0];
                        state_r <= instr_nxt[15] ? acsp_pkg::ST_RDATA
                                                 : acsp_pkg::ST_WDATA;
                    end
                end
                acsp_pkg::ST_WDATA, acsp_pkg::ST_RDATA: begin
                    bcnt_r <= (bcnt_r == 4'h7) ? 4'h0 : bcnt_r + 4'h1;
                    if (bcnt_r == 4'h7) begin
                        addr_r <= addr_r + 15'h0001;
                    end
                end
                default: state_r <= acsp_pkg::ST_INSTR;
            endcase
        end
    end

    // write shifter
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wsh_r <= 8'h00;
        end else if (rise && state_r == acsp_pkg::ST_WDATA) begin
            wsh_r <= wsh_nxt;
        end
    end

    assign req.wr    = byte_done && state_r == acsp_pkg::ST_WDATA;
    assign req.rd    = instr_done && instr_nxt[15];
    assign req.addr  = req.rd ? instr_nxt[14:0] : addr_r;
    assign req.wdata = wsh_nxt;

    // ****************************************************************
    // register file
    // ****************************************************************
    // soft reset code in interface config
    assign srst_go = req.wr && req.addr == acsp_pkg::ADDR_IFCFG
                     && req.wdata == acsp_pkg::SOFT_RESET_CODE;

    // defaults on hard and soft reset; global copies
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ifcfg_r   <= acsp_pkg::IFCFG_RST;
            chsel_r   <= acsp_pkg::CHSEL_RST[1:0];
            outmode_r <= acsp_pkg::OUTMODE_RST;
        end else if (srst_go) begin
            ifcfg_r   <= acsp_pkg::IFCFG_RST;
            chsel_r   <= acsp_pkg::CHSEL_RST[1:0];
            outmode_r <= acsp_pkg::OUTMODE_RST;
        end else if (req.wr) begin
            if (req.addr == acsp_pkg::ADDR_IFCFG) begin
                // soft reset bits self clear, never stored
                ifcfg_r <= req.wdata & 8'h7e;
            end
            if (req.addr == acsp_pkg::ADDR_CHSEL) begin
                chsel_r <= req.wdata[1:0];
            end
            if (req.addr == acsp_pkg::ADDR_OUTMODE) begin
                outmode_r <= req.wdata;
            end
        end
    end

    // local copies steered by channel bits; both set writes both
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            term_a_r <= acsp_pkg::TERM_RST;
            term_b_r <= acsp_pkg::TERM_RST;
        end else if (srst_go) begin
            term_a_r <= acsp_pkg::TERM_RST;
            term_b_r <= acsp_pkg::TERM_RST;
        end else if (req.wr && req.addr == acsp_pkg::ADDR_TERM) begin
            if (chsel_r[acsp_pkg::CH_A_BIT]) begin
                term_a_r <= req.wdata;
            end
            if (chsel_r[acsp_pkg::CH_B_BIT]) begin
                term_b_r <= req.wdata;
            end
        end
    end

    // bit order live from either mirrored lsb-first bit
    assign lsb_first_r = ifcfg_r[acsp_pkg::LSB_FIRST_BIT] | ifcfg_r[acsp_pkg::LSB_FIRST_BIT_M];

    // read mux; unmapped locations read zero
    always_comb begin
        rd_val = 8'h00;
        unique case (req.addr)
            acsp_pkg::ADDR_IFCFG:   rd_val = ifcfg_r;
            acsp_pkg::ADDR_CHSEL:   rd_val = {6'h00, chsel_r};
            // channel A wins when both are selected
            acsp_pkg::ADDR_TERM:    rd_val = chsel_r[acsp_pkg::CH_A_BIT] ? term_a_r : term_b_r;
            acsp_pkg::ADDR_OUTMODE: rd_val = outmode_r;
            default:                rd_val = 8'h00;
        endcase
    end

    // read shifter: load at instruction end and each byte boundary of a read
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsh_r        <= 8'h00;
            rdata_load_r <= 1'b0;
        end else begin
            rdata_load_r <= byte_done && state_r == acsp_pkg::ST_RDATA;
            if (req.rd) begin
                rsh_r <= rd_val;
            end else if (rdata_load_r) begin
                rsh_r <= rd_val;
            end else if (fall && state_r == acsp_pkg::ST_RDATA && bcnt_r != 4'h0) begin
                // shift after the host sampled on the rising edge
                rsh_r <= lsb_first_r ? {1'b0, rsh_r[7:1]} : {rsh_r[6:0], 1'b0};
            end
        end
    end

    // drive only in read data phase while selected; release when high
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sdio_oe_o <= 1'b0;
        end else begin
            sdio_oe_o <= ~sel_n_s && state_r == acsp_pkg::ST_RDATA && in_frame_r;
        end
    end
    assign sdio_o = lsb_first_r ? rsh_r[0] : rsh_r[7];

    // select idle high hands pins to secondary use until the first clocked frame after hard or soft reset
    assign sec_fn_en_o = sel_n_s & ~in_frame_r;

    // soft reset recovery timer
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            srst_cnt_r <= 32'h0000_0000;
        end else if (srst_go) begin
            srst_cnt_r <= 32'(SRST_CYCLES);
        end else if (srst_cnt_r != 32'h0000_0000) begin
            srst_cnt_r <= srst_cnt_r - 32'h0000_0001;
        end
    end
    assign soft_rst_busy_o = srst_cnt_r != 32'h0000_0000;

    assign term_a_o   = term_a_r;
    assign term_b_o   = term_b_r;
    assign out_mode_o = outmode_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_oe_only_read;
        @(posedge mclk_i) disable iff (!arst_n_i)
        sdio_oe_o |-> $past(state_r) == acsp_pkg::ST_RDATA;
    endproperty
    a_oe_only_read: assert property (p_oe_only_read) else $error("drive outside read");

    property p_dir_write;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (instr_done && !instr_nxt[15] && !srst_go) |=> state_r == acsp_pkg::ST_WDATA;
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("write not decoded");

    property p_dir_read;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (instr_done && instr_nxt[15]) |=> state_r == acsp_pkg::ST_RDATA;
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("read not decoded");

    property p_both_write;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (req.wr && req.addr == acsp_pkg::ADDR_TERM && chsel_r == 2'h3)
            |=> term_a_r == term_b_r;
    endproperty
    a_both_write: assert property (p_both_write) else $error("dual write missed");

    property p_srst;
        @(posedge mclk_i) disable iff (!arst_n_i)
        srst_go |=> outmode_r == acsp_pkg::OUTMODE_RST && soft_rst_busy_o;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset not taken");

    property p_hold_stall;
        @(posedge mclk_i) disable iff (!arst_n_i)
        sel_n_s |=> $stable(bcnt_r) || $past(srst_go);
    endproperty
    a_hold_stall: assert property (p_hold_stall) else $error("stall lost position");

    property p_hiz_idle;
        @(posedge mclk_i) disable iff (!arst_n_i)
        sel_n_s [*2] |-> !sdio_oe_o;
    endproperty
    a_hiz_idle: assert property (p_hiz_idle) else $error("pin driven while idle");

    property p_stream_inc;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (byte_done && !srst_go) |=> addr_r == $past(addr_r) + 15'h0001;
    endproperty
    a_stream_inc: assert property (p_stream_inc) else $error("address not advanced");

    property p_chan_a_read;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (req.addr == acsp_pkg::ADDR_TERM && chsel_r[0]) |-> rd_val == term_a_r;
    endproperty
    a_chan_a_read: assert property (p_chan_a_read) else $error("wrong channel read");
endmodule // acsp_port

//--- hdl/acsp_sync.sv
// two-flop synchroniser for asynchronous pin levels
module acsp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         mclk_i,
    input  wire logic         arst_n_i,
    // level in and out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // first stage is read only by the second; reset to the pins' idle levels
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule // acsp_sync

//--- inc/acsp_pkg.sv
package acsp_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [14:0] ADDR_IFCFG   = 15'h000;
    localparam logic [14:0] ADDR_CHSEL   = 15'h008;
    localparam logic [14:0] ADDR_TERM    = 15'h016;
    localparam logic [14:0] ADDR_OUTMODE = 15'h561;

    // ****************************************************************
    // fields, codes and reset values
    // ****************************************************************
    localparam logic [7:0] SOFT_RESET_CODE = 8'h81;
    localparam int         LSB_FIRST_BIT   = 6;
    localparam int         LSB_FIRST_BIT_M = 1;
    localparam int         CH_A_BIT        = 0;
    localparam int         CH_B_BIT        = 1;
    localparam logic [7:0] IFCFG_RST       = 8'h00;
    localparam logic [7:0] CHSEL_RST       = 8'h00;
    localparam logic [7:0] TERM_RST        = 8'h00;
    localparam logic [7:0] OUTMODE_RST     = 8'h01;
    localparam logic [1:0] CHSEL_MASK      = 2'h3;

    // ****************************************************************
    // frame geometry and timing
    // ****************************************************************
    localparam int          WORD_BITS  = 8;
    localparam int          INSTR_BITS = 16;
    localparam int          CLK_MHZ    = 250;
    localparam int          SRST_US    = 5000;
    localparam int          SRST_CYC   = SRST_US * CLK_MHZ;

    // one register access decoded from the serial frame
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } acsp_req_t;

    // frame shifter state
    typedef enum logic [1:0] {
        ST_INSTR = 2'b00,
        ST_WDATA = 2'b01,
        ST_RDATA = 2'b10
    } acsp_state_t;

endpackage

//--- tb/acsp_host.sv
// serial master standing in for the host controller
module acsp_host (
    // serial pins toward the device
    output logic      sclk_o,
    output logic      port_select_n_o,
    output logic      sdio_w_o,
    // device side of the data pin
    input  wire logic sdio_i,
    input  wire logic sdio_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // pin state
    // ****************************************************************
    localparam realtime HALF = 62.5;
    logic host_oe = 1'b1;
    logic dat     = 1'b0;

    initial begin
        sclk_o          = 1'b0;
        port_select_n_o = 1'b1;
    end

    // device wins, released line shows inverse of last bit
    assign sdio_w_o = sdio_oe_i ? sdio_i : (host_oe ? dat : ~dat);

    // ****************************************************************
    // one clock bit: data set while low, sampled at rise
    // ****************************************************************
    task automatic clk_bit(input logic b, input logic rel, output logic r);
        if (host_oe) begin
            dat = b;
        end
        #(HALF);
        sclk_o = 1'b1;
        r      = sdio_w_o;
        #(HALF);
        sclk_o = 1'b0;
        // host lets go only after the device has taken the last instruction bit
        if (rel) begin
            host_oe = 1'b0;
        end
    endtask

    // ****************************************************************
    // whole frame: instruction then one or more words
    // ****************************************************************
    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd[$],
                        input logic stall, input int lsb_from, output logic [7:0] rq[$]);
        logic [15:0] ins;
        logic [7:0]  byt;
        logic        b;
        int          idx;
        ins     = {rd, addr};
        rq      = {};
        host_oe = 1'b1;
        // select low, then rising clock starts the frame
        port_select_n_o = 1'b0;
        // direction bit, then address, always msb first
        for (int i = 15; i >= 0; i--) begin
            clk_bit(ins[i], rd && (i == 0), b);
        end
        for (int k = 0; k < wd.size(); k++) begin
            // stall between words with the clock parked low
            if (stall && k > 0) begin
                port_select_n_o = 1'b1;
                #(4 * HALF);
                port_select_n_o = 1'b0;
            end
            for (int j = 0; j < 8; j++) begin
                idx = (k >= lsb_from) ? j : 7 - j;
                clk_bit(wd[k][idx], 1'b0, b);
                byt[idx] = b;
            end
            rq.push_back(byt);
        end
        #(HALF);
        port_select_n_o = 1'b1;
        host_oe         = 1'b1;
        #(4 * HALF);
    endtask
endmodule // acsp_host

//--- tb/adc_config_serial_port_test.sv
module adc_config_serial_port_test;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // signals
    // ****************************************************************
    localparam int SRST_N = 20; // short recovery keeps the run brief
    logic       mclk   = 1'b0;
    logic       arst_n = 1'b0;
    logic       sclk;
    logic       sel_n;
    logic       sdio_w;
    logic       sdio_o;
    logic       sdio_oe;
    logic       sec_fn;
    logic       busy;
    logic [7:0] term_a;
    logic [7:0] term_b;
    logic [7:0] out_mode;
    logic [7:0] wq[$];
    logic [7:0] rq[$];
    int         num_errors = 0;
    int         cmp_count  = 0;
    int         busy_cnt   = 0;

    initial begin
        forever #2 mclk = ~mclk;
    end

    // busy pulse is shorter than a frame tail, so count it here
    always @(negedge mclk) begin
        if (busy === 1'b1) begin
            busy_cnt++;
        end
    end

    acsp_port #(.SRST_CYCLES(SRST_N)) dut (
        .mclk_i         (mclk),
        .arst_n_i       (arst_n),
        .sclk_i         (sclk),
        .port_select_n_i(sel_n),
        .sdio_i         (sdio_w),
        .sdio_o         (sdio_o),
        .sdio_oe_o      (sdio_oe),
        .sec_fn_en_o    (sec_fn),
        .soft_rst_busy_o(busy),
        .term_a_o       (term_a),
        .term_b_o       (term_b),
        .out_mode_o     (out_mode)
    );

    acsp_host host (
        .sclk_o         (sclk),
        .port_select_n_o(sel_n),
        .sdio_w_o       (sdio_w),
        .sdio_i         (sdio_o),
        .sdio_oe_i      (sdio_oe)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_reset();
        @(negedge mclk);
        arst_n = 1'b0;
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        repeat (8) @(negedge mclk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_defaults();
        do_reset();
        check("out_mode", out_mode, 8'h01);
        check("term_a", term_a, 8'h00);
        check("term_b", term_b, 8'h00);
        check("oe idle", sdio_oe, 1'b0);
        check("sec_fn idle", sec_fn, 1'b1);
        wq = {8'h00, 8'h00};
        host.xfer(1'b1, 15'h560, wq, 1'b0, 99, rq); // open location is only read
        check("rd unmapped", rq[0], 8'h00);
        check("rd out_mode", rq[1], 8'h01);
        check("sec_fn used", sec_fn, 1'b0);
        check("oe released", sdio_oe, 1'b0);
        $display("done defaults");
    endtask

    task automatic t_lsb_chan_a();
        do_reset();
        wq = {8'h42};
        repeat (7) wq.push_back(8'h00);
        wq.push_back(8'h01);
        repeat (13) wq.push_back(8'h00);
        wq.push_back(8'h1d);
        host.xfer(1'b0, acsp_pkg::ADDR_IFCFG, wq, 1'b0, 1, rq);
        check("lsb term_a", term_a, 8'h1d);
        check("lsb term_b", term_b, 8'h00);
        $display("done lsb_chan_a");
    endtask

    task automatic t_stall_chan_b();
        do_reset();
        wq = {8'h02};
        repeat (13) wq.push_back(8'h00);
        wq.push_back(8'hc3);
        host.xfer(1'b0, acsp_pkg::ADDR_CHSEL, wq, 1'b1, 99, rq);
        check("stall term_b", term_b, 8'hc3);
        check("stall term_a", term_a, 8'h00);
        $display("done stall_chan_b");
    endtask

    task automatic t_both();
        do_reset();
        wq = {8'h03};
        repeat (13) wq.push_back(8'h00);
        wq.push_back(8'ha5);
        wq.push_back(8'h77);
        host.xfer(1'b0, acsp_pkg::ADDR_CHSEL, wq, 1'b0, 99, rq);
        check("both term_a", term_a, 8'ha5);
        check("both term_b", term_b, 8'ha5);
        check("global out", out_mode, 8'h01);
        $display("done both");
    endtask

    task automatic t_soft();
        do_reset();
        busy_cnt = 0;
        wq = {acsp_pkg::SOFT_RESET_CODE};
        host.xfer(1'b0, acsp_pkg::ADDR_IFCFG, wq, 1'b0, 99, rq);
        repeat (SRST_N + 8) @(negedge mclk);
        check("busy len", busy_cnt >= SRST_N && busy_cnt <= SRST_N + 2, 1'b1);
        check("busy done", busy, 1'b0);
        check("sec_fn back", sec_fn, 1'b1);
        check("srst out_mode", out_mode, 8'h01);
        wq = {8'h00}; // unused bits written as zero
        host.xfer(1'b0, acsp_pkg::ADDR_OUTMODE, wq, 1'b0, 99, rq);
        check("new frame", out_mode, 8'h00);
        $display("done soft");
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        t_defaults();
        t_lsb_chan_a();
        t_stall_chan_b();
        t_both();
        t_soft();
        stop_test();
    end

    // whole run needs about 75 us; a hang is cut well past that
    initial begin
        #300us;
        num_errors++;
        $display("ERROR watchdog expected finish seen hang");
        stop_test();
    end
endmodule // adc_config_serial_port_test
